// file: verilog/fcl_top.sv
// flash command launcher: divider, command object, mode check, launch
// Function
// RULE_01: software loads divider after reset for 1 MHz
// RULE_02: no program or erase below 0.8 MHz bus
// RULE_03: divider write sets the loaded flag
// RULE_04: unloaded divider blocks program/erase, sets bad sequence
// RULE_05: software clears error flags and checks complete first
// RULE_06: busy ignores command object writes
// RULE_07: software loads parameters and sets word index
// RULE_08: writing one to complete flag launches command
// RULE_09: complete flag clear until done, results returned
// RULE_10: info row readable only in resource window
// RULE_11: mode and security inputs select valid codes
// RULE_12: codes 01, 02, 13 valid everywhere
// RULE_13: codes 08, 0B only in special mode
// RULE_14: code 0C only in normal single chip
// RULE_15: code 0E only unsecured special mode
// RULE_16: listed codes invalid in secured special mode
// RULE_17: 02 verifies one block, 01 verifies all
// RULE_18: 03 verifies a counted section erased
// RULE_19: 07 programs info field once, 04 reads
// RULE_20: 06 programs phrase, 0A erases sector
// RULE_21: 08 needs all four protection opens set
// RULE_22: 09 needs three program flash opens set
// RULE_23: six sixteen-bit words, code in word zero high
// RULE_24: each word has separately writable bytes
// RULE_25: invalid code sets bad sequence, not processed
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module fcl_top (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [3:0]  avs_byteenable_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // mode pins
    input  wire logic        special_mode_in,
    input  wire logic        secure_state_in,
    input  wire logic        resource_window_in,
    // array engine
    output logic             eng_start_out,
    output logic      [7:0]  eng_cmd_out,
    output logic      [23:0] eng_addr_out,
    output logic      [63:0] eng_data_out,
    output logic      [2:0]  eng_count_out,
    output logic             flash_tick_out,
    input  wire logic        eng_done_in,
    input  wire logic        eng_viol_in,
    input  wire logic [63:0] eng_result_in
);
    fcl_pkg::fcl_regs_type r;
    fcl_pkg::fcl_regs_type n;
    logic       req;
    logic       wr_acc;
    logic       rd_first;
    logic [7:0] cmd;
    logic       ss;
    logic       sec;
    logic       ccob_hit;
    logic [2:0] wsel;
    logic [2:0] phr;
    logic [31:0] rd_mux;

    // mode/security gate per command code
    function automatic logic cmd_ok(input logic [7:0] c,
                                    input logic ss_f,
                                    input logic sec_f);
        case (c)
            fcl_pkg::CMD_EV_ALL,
            fcl_pkg::CMD_EV_BLK,
            fcl_pkg::CMD_OVERRIDE: cmd_ok = 1'b1;        // [RULE_12]
            fcl_pkg::CMD_ERS_ALL,
            fcl_pkg::CMD_UNSEC:    cmd_ok = ss_f;        // [RULE_13]
            fcl_pkg::CMD_KEY:      cmd_ok = !ss_f;       // [RULE_14]
            fcl_pkg::CMD_FMARGIN:  cmd_ok = ss_f && !sec_f; // [RULE_15]
            fcl_pkg::CMD_EV_SECT,
            fcl_pkg::CMD_RD_ONCE,
            fcl_pkg::CMD_PGM,
            fcl_pkg::CMD_PGM_ONCE,
            fcl_pkg::CMD_ERS_BLK,
            fcl_pkg::CMD_ERS_SECT,
            fcl_pkg::CMD_UMARGIN,
            fcl_pkg::CMD_EV_EE,
            fcl_pkg::CMD_PGM_EE,
            fcl_pkg::CMD_ERS_EE:   cmd_ok = !(ss_f && sec_f); // [RULE_16]
            default:               cmd_ok = 1'b0;
        endcase
    endfunction : cmd_ok

    // commands that change array contents need the time base
    function automatic logic cmd_pe(input logic [7:0] c);
        case (c)
            fcl_pkg::CMD_PGM,
            fcl_pkg::CMD_PGM_ONCE,
            fcl_pkg::CMD_ERS_ALL,
            fcl_pkg::CMD_ERS_BLK,
            fcl_pkg::CMD_ERS_SECT,
            fcl_pkg::CMD_UNSEC,
            fcl_pkg::CMD_PGM_EE,
            fcl_pkg::CMD_ERS_EE: cmd_pe = 1'b1;
            default:             cmd_pe = 1'b0;
        endcase
    endfunction : cmd_pe

    assign req      = avs_read_in || avs_write_in;
    assign wr_acc   = avs_write_in && r.ack;
    assign rd_first = avs_read_in && !r.ack;
    assign cmd      = r.ccob[0][15:8];                    // [RULE_23]
    assign ss       = r.filt[fcl_pkg::MODE_SPECIAL];      // [RULE_11]
    assign sec      = r.filt[fcl_pkg::MODE_SECURE];       // [RULE_11]
    assign wsel     = avs_address_in[4:2];
    assign ccob_hit = (avs_address_in[7:5] == 3'h1) &&
                      (wsel < 3'(fcl_pkg::CCOB_WORDS));
    assign phr      = r.ccob[1][2:0];

    // read data mux, sampled on the request's first cycle
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address_in[7]) begin
            if (r.filt[fcl_pkg::MODE_WINDOW]) begin       // [RULE_10]
                rd_mux = {16'h0000, r.info[avs_address_in[6:2]]};
            end
        end else if (ccob_hit) begin
            rd_mux = {16'h0000, r.ccob[wsel]};
        end else begin
            case ({avs_address_in[7:2], 2'b00})
                fcl_pkg::OFS_DIV:
                    rd_mux = {24'h000000, r.div_ld, r.div};
                fcl_pkg::OFS_STAT: begin
                    rd_mux[fcl_pkg::STAT_COMMAND_COMPLETE_FLAG]   = r.command_complete_flag;
                    rd_mux[fcl_pkg::STAT_BAD_SEQUENCE_FLAG] = r.bad_sequence_flag;
                    rd_mux[fcl_pkg::STAT_PVIOL]  = r.pviol;
                end
                fcl_pkg::OFS_IDX:  rd_mux = {29'h0, r.ix};
                fcl_pkg::OFS_PROT: rd_mux = {28'h0, r.prot};
                fcl_pkg::OFS_MODE: rd_mux = {29'h0, r.filt};
                default:           rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        n       = r;
        n.start = 1'b0;
        n.tick  = 1'b0;
        // pins: three stages, value moves once stages two and three agree
        n.s1 = {resource_window_in, secure_state_in, special_mode_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < 3; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.filt[i] = r.s3[i];
            end
        end
        // time base: one tick every div+1 bus clocks once loaded
        if (r.tcnt >= r.div) begin
            n.tcnt = 7'h00;
            n.tick = r.div_ld;
        end else begin
            n.tcnt = r.tcnt + 7'h01;
        end
        // one wait cycle per access
        n.ack = req && !r.ack;
        if (rd_first) begin
            n.rdata = rd_mux;
        end
        if (wr_acc) begin
            if (ccob_hit) begin
                if (r.command_complete_flag) begin                         // [RULE_06]
                    if (avs_byteenable_in[0]) begin       // [RULE_24]
                        n.ccob[wsel][7:0] = avs_writedata_in[7:0];
                    end
                    if (avs_byteenable_in[1]) begin       // [RULE_24]
                        n.ccob[wsel][15:8] = avs_writedata_in[15:8];
                    end
                end
            end else begin
                case ({avs_address_in[7:2], 2'b00})
                    fcl_pkg::OFS_DIV: begin
                        if (avs_byteenable_in[0]) begin
                            n.div    = avs_writedata_in[6:0];
                            n.div_ld = 1'b1;              // [RULE_03]
                        end
                    end
                    fcl_pkg::OFS_STAT: begin
                        if (avs_byteenable_in[0]) begin
                            if (avs_writedata_in[fcl_pkg::STAT_BAD_SEQUENCE_FLAG]) begin
                                n.bad_sequence_flag = 1'b0;
                            end
                            if (avs_writedata_in[fcl_pkg::STAT_PVIOL]) begin
                                n.pviol = 1'b0;
                            end
                            // launch only from idle with clean flags
                            if (avs_writedata_in[fcl_pkg::STAT_COMMAND_COMPLETE_FLAG] &&
                                r.command_complete_flag && !r.bad_sequence_flag && !r.pviol) begin
                                n.command_complete_flag = 1'b0;            // [RULE_08]
                                n.fsm  = fcl_pkg::FCL_CHECK;
                            end
                        end
                    end
                    fcl_pkg::OFS_IDX: begin
                        if (avs_byteenable_in[0] && r.command_complete_flag) begin
                            n.ix = avs_writedata_in[2:0]; // [RULE_06]
                        end
                    end
                    fcl_pkg::OFS_PROT: begin
                        if (avs_byteenable_in[0]) begin
                            n.prot = avs_writedata_in[3:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // command sequencing; hardware sets land after software clears
        case (r.fsm)
            fcl_pkg::FCL_IDLE: begin
            end
            fcl_pkg::FCL_CHECK: begin
                n.fsm = fcl_pkg::FCL_FINISH;
                if (!cmd_ok(cmd, ss, sec)) begin
                    n.bad_sequence_flag = 1'b1;                      // [RULE_25]
                end else if (cmd_pe(cmd) && !r.div_ld) begin
                    n.bad_sequence_flag = 1'b1;                      // [RULE_04]
                end else if (cmd == fcl_pkg::CMD_ERS_ALL &&
                             r.prot != fcl_pkg::PROT_ALL) begin
                    n.pviol = 1'b1;                       // [RULE_21]
                end else if (cmd == fcl_pkg::CMD_ERS_BLK &&
                             r.prot[2:0] != fcl_pkg::PROT_PF) begin
                    n.pviol = 1'b1;                       // [RULE_22]
                end else if (cmd == fcl_pkg::CMD_PGM_ONCE) begin
                    // each 8-byte phrase of the 64-byte field is one-shot
                    if (r.once[phr]) begin
                        n.bad_sequence_flag = 1'b1;                  // [RULE_19]
                    end else begin
                        n.once[phr] = 1'b1;
                        for (int j = 0; j < 4; j++) begin
                            n.info[{phr, 2'(j)}] = r.ccob[3'(2 + j)];
                        end
                    end
                end else if (cmd == fcl_pkg::CMD_RD_ONCE) begin
                    for (int j = 0; j < 4; j++) begin     // [RULE_19]
                        n.ccob[3'(2 + j)] = r.info[{phr, 2'(j)}];
                    end
                end else begin
                    // verify, program, erase and margin go to the array
                    n.start = 1'b1; // [RULE_17] [RULE_18] [RULE_20]
                    n.fsm   = fcl_pkg::FCL_RUN;
                end
            end
            fcl_pkg::FCL_RUN: begin
                if (eng_done_in) begin
                    n.ccob[5:2] = eng_result_in;          // [RULE_09]
                    if (eng_viol_in) begin
                        n.pviol = 1'b1;
                    end
                    n.fsm = fcl_pkg::FCL_FINISH;
                end
            end
            fcl_pkg::FCL_FINISH: begin
                n.command_complete_flag = 1'b1;                            // [RULE_09]
                n.fsm  = fcl_pkg::FCL_IDLE;
            end
            default: n.fsm = fcl_pkg::FCL_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            r      <= '0;
            r.div  <= fcl_pkg::DIV_RST;
            r.command_complete_flag <= fcl_pkg::COMMAND_COMPLETE_FLAG_RST;
            r.prot <= fcl_pkg::PROT_RST;
            r.fsm  <= fcl_pkg::FCL_IDLE;
        end else begin
            r <= n;
        end
    end

    assign avs_readdata_out    = r.rdata;
    assign avs_waitrequest_out = req && !r.ack;
    assign eng_start_out       = r.start;
    assign eng_cmd_out         = cmd;
    assign eng_addr_out        = {r.ccob[0][7:0], r.ccob[1]};
    assign eng_data_out        = r.ccob[5:2];
    assign eng_count_out       = r.ix;
    assign flash_tick_out      = r.tick;

    // checks
    logic div_wr;
    logic stat_launch;
    assign div_wr = wr_acc && avs_byteenable_in[0] &&
                    ({avs_address_in[7:2], 2'b00} == fcl_pkg::OFS_DIV);
    assign stat_launch = wr_acc && avs_byteenable_in[0] &&
                    ({avs_address_in[7:2], 2'b00} == fcl_pkg::OFS_STAT) &&
                    avs_writedata_in[fcl_pkg::STAT_COMMAND_COMPLETE_FLAG] &&
                    r.command_complete_flag && !r.bad_sequence_flag && !r.pviol;

    sequence s_check_fail;
        !eng_start_out ##1 r.fsm == fcl_pkg::FCL_IDLE && r.command_complete_flag;
    endsequence

    property p_div_flag;
        @(posedge clk_in) disable iff (rst_in)
        div_wr |=> r.div_ld;
    endproperty
    a_div_flag: assert property (p_div_flag) // [RULE_03]
        else $error("divider write did not set loaded flag");

    property p_no_div;
        @(posedge clk_in) disable iff (rst_in)
        (r.fsm == fcl_pkg::FCL_CHECK && cmd_ok(cmd, ss, sec) &&
         cmd_pe(cmd) && !r.div_ld) |=> r.bad_sequence_flag ##0 s_check_fail;
    endproperty
    a_no_div: assert property (p_no_div) // [RULE_04]
        else $error("program without divider was not refused");

    property p_ignore;
        @(posedge clk_in) disable iff (rst_in)
        (wr_acc && ccob_hit && !r.command_complete_flag && r.fsm != fcl_pkg::FCL_CHECK &&
         !eng_done_in) |=> $stable(r.ccob[5:0]);
    endproperty
    a_ignore: assert property (p_ignore) // [RULE_06]
        else $error("command object changed while busy");

    property p_launch;
        @(posedge clk_in) disable iff (rst_in)
        stat_launch |=> !r.command_complete_flag && r.fsm == fcl_pkg::FCL_CHECK;
    endproperty
    a_launch: assert property (p_launch) // [RULE_08]
        else $error("launch write did not start a command");

    property p_busy;
        @(posedge clk_in) disable iff (rst_in)
        eng_start_out |-> !r.command_complete_flag throughout
            (r.fsm == fcl_pkg::FCL_RUN ##1 r.fsm == fcl_pkg::FCL_RUN);
    endproperty
    a_busy: assert property (p_busy) // [RULE_09]
        else $error("complete flag set during execution");

    property p_done;
        @(posedge clk_in) disable iff (rst_in)
        (r.fsm == fcl_pkg::FCL_RUN && eng_done_in) |->
            ##1 !r.command_complete_flag ##1 r.command_complete_flag && r.fsm == fcl_pkg::FCL_IDLE;
    endproperty
    a_done: assert property (p_done) // [RULE_09]
        else $error("completion not reported two cycles after done");

    property p_window;
        @(posedge clk_in) disable iff (rst_in)
        (rd_first && avs_address_in[7] && !r.filt[fcl_pkg::MODE_WINDOW])
            |=> avs_readdata_out == 32'h0000_0000;
    endproperty
    a_window: assert property (p_window) // [RULE_10]
        else $error("info row readable outside window");

    property p_invalid;
        @(posedge clk_in) disable iff (rst_in)
        (r.fsm == fcl_pkg::FCL_CHECK && !cmd_ok(cmd, ss, sec))
            |=> r.bad_sequence_flag ##0 s_check_fail;
    endproperty
    a_invalid: assert property (p_invalid) // [RULE_25]
        else $error("invalid command was processed");

    property p_field_margin;
        @(posedge clk_in) disable iff (rst_in)
        (r.fsm == fcl_pkg::FCL_CHECK && cmd == fcl_pkg::CMD_FMARGIN &&
         !(ss && !sec)) |=> r.bad_sequence_flag && !eng_start_out;
    endproperty
    a_field_margin: assert property (p_field_margin) // [RULE_15]
        else $error("field margin accepted outside unsecured special");

    property p_protect;
        @(posedge clk_in) disable iff (rst_in)
        (r.fsm == fcl_pkg::FCL_CHECK && cmd == fcl_pkg::CMD_ERS_ALL &&
         ss && r.div_ld && r.prot != fcl_pkg::PROT_ALL)
            |=> r.pviol && !eng_start_out;
    endproperty
    a_protect: assert property (p_protect) // [RULE_21]
        else $error("erase all launched with protection closed");
endmodule : fcl_top

// file: verilog/fcl_pkg.sv
// constants and types for the flash command launcher
package fcl_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_DIV    = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_IDX    = 8'h08;
    localparam logic [7:0] OFS_PROT   = 8'h0c;
    localparam logic [7:0] OFS_MODE   = 8'h10;
    localparam logic [7:0] OFS_CCOB   = 8'h20;
    localparam logic [7:0] OFS_INFO   = 8'h80;
    localparam int         CCOB_WORDS = 6;
    // field positions
    localparam int DIV_LD_BIT   = 7;
    localparam int STAT_COMMAND_COMPLETE_FLAG    = 7;
    localparam int STAT_BAD_SEQUENCE_FLAG  = 5;
    localparam int STAT_PVIOL   = 4;
    localparam int MODE_SPECIAL = 0;
    localparam int MODE_SECURE  = 1;
    localparam int MODE_WINDOW  = 2;
    // reset values and protection masks
    localparam logic [6:0] DIV_RST  = 7'h00;
    localparam logic       COMMAND_COMPLETE_FLAG_RST = 1'b1;
    localparam logic [3:0] PROT_RST = 4'h0;
    localparam logic [3:0] PROT_ALL = 4'hf;
    localparam logic [2:0] PROT_PF  = 3'h7;
    // command codes
    localparam logic [7:0] CMD_EV_ALL   = 8'h01;
    localparam logic [7:0] CMD_EV_BLK   = 8'h02;
    localparam logic [7:0] CMD_EV_SECT  = 8'h03;
    localparam logic [7:0] CMD_RD_ONCE  = 8'h04;
    localparam logic [7:0] CMD_PGM      = 8'h06;
    localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
    localparam logic [7:0] CMD_ERS_ALL  = 8'h08;
    localparam logic [7:0] CMD_ERS_BLK  = 8'h09;
    localparam logic [7:0] CMD_ERS_SECT = 8'h0a;
    localparam logic [7:0] CMD_UNSEC    = 8'h0b;
    localparam logic [7:0] CMD_KEY      = 8'h0c;
    localparam logic [7:0] CMD_UMARGIN  = 8'h0d;
    localparam logic [7:0] CMD_FMARGIN  = 8'h0e;
    localparam logic [7:0] CMD_EV_EE    = 8'h10;
    localparam logic [7:0] CMD_PGM_EE   = 8'h11;
    localparam logic [7:0] CMD_ERS_EE   = 8'h12;
    localparam logic [7:0] CMD_OVERRIDE = 8'h13;

    typedef enum logic [1:0] {
        FCL_IDLE   = 2'b00,
        FCL_CHECK  = 2'b01,
        FCL_RUN    = 2'b11,
        FCL_FINISH = 2'b10
    } fcl_fsm_type;

    typedef struct packed {
        fcl_fsm_type       fsm;
        logic              ack;
        logic [31:0]       rdata;
        logic [6:0]        div;
        logic              div_ld;
        logic [6:0]        tcnt;
        logic              tick;
        logic              command_complete_flag;
        logic              bad_sequence_flag;
        logic              pviol;
        logic [2:0]        ix;
        logic [3:0]        prot;
        logic [5:0][15:0]  ccob;
        logic [31:0][15:0] info;
        logic [7:0]        once;
        logic [2:0]        s1;
        logic [2:0]        s2;
        logic [2:0]        s3;
        logic [2:0]        filt;
        logic              start;
    } fcl_regs_type;
endpackage : fcl_pkg

// file: tb/testbench.sv
// self-checking bench for the flash command launcher
`timescale 1ns/1ps
module testbench;
    logic        clk_in;
    logic        rst_in;
    logic [7:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        special_mode_in;
    logic        secure_state_in;
    logic        resource_window_in;
    logic        eng_start_out;
    logic [7:0]  eng_cmd_out;
    logic [23:0] eng_addr_out;
    logic [63:0] eng_data_out;
    logic [2:0]  eng_count_out;
    logic        flash_tick_out;
    logic        eng_done_in;
    logic        eng_viol_in;
    logic [63:0] eng_result_in;
    int          n_fail;
    int          n_tests;
    logic        viol_req;
    logic [31:0] exp_q[$];
    logic [31:0] rd;
    logic [15:0] dw [2:5];
    logic [15:0] pdat;
    logic [7:0]  codes [18];

    fcl_top fcl_top_i (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .special_mode_in,
        .secure_state_in, .resource_window_in, .eng_start_out, .eng_cmd_out,
        .eng_addr_out, .eng_data_out, .eng_count_out, .flash_tick_out,
        .eng_done_in, .eng_viol_in, .eng_result_in);

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // master holds the request until a rising edge samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        do begin
            @(posedge clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        if (avs_waitrequest_out !== 1'b0) begin
            n_fail++;
            complete_run();
        end
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask : bus

    task automatic rchk(input logic [7:0] a, input string nm,
                        input logic [31:0] mask, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, rd & mask, exp);
    endtask : rchk

    task automatic clr();
        bus(1'b1, 8'h04, 32'h30, 4'h1);
    endtask : clr

    // loads all six words, launches, polls until complete; status left in rd
    task automatic launch(input logic [7:0] c, input logic [23:0] ad,
                          input logic poke, input logic ext);
        int n;
        n = 0;
        bus(1'b1, 8'h20, {16'h0, c, ad[23:16]}, 4'h3);
        bus(1'b1, 8'h24, {16'h0, ad[15:0]}, 4'h3);
        for (int k = 2; k < 6; k++) begin
            dw[k] = 16'($urandom);
            bus(1'b1, 8'(8'h20 + 4 * k), {16'h0, dw[k]}, 4'h3);
        end
        bus(1'b1, 8'h08, 32'h5, 4'h1);
        if (ext) begin
            exp_q.push_back({c, ad});
        end
        bus(1'b1, 8'h04, 32'h80, 4'h1);
        if (poke) begin
            bus(1'b1, 8'h20, 32'hffff, 4'h3);
            rchk(8'h04, "busy flag", 32'h80, 32'h0);
        end
        rd = 32'h0;
        while (rd[7] !== 1'b1 && n < 100) begin
            bus(1'b0, 8'h04, 32'h0, 4'h1);
            n++;
        end
        if (n == 100) begin
            n_fail++;
            complete_run();
        end
    endtask : launch

    function automatic logic valid_cmd(input logic [7:0] c, input logic ss,
                                       input logic sec);
        case (c)
            8'h01, 8'h02, 8'h13: return 1'b1;
            8'h08, 8'h0b: return ss;
            8'h0c: return !ss;
            8'h0e: return ss && !sec;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11,
            8'h12: return !(ss && sec);
            default: return 1'b0;
        endcase
    endfunction : valid_cmd

    // engine side: checks each start against the oldest note, then answers
    initial begin
        {eng_done_in, eng_viol_in, eng_result_in} = '0;
        forever begin
            @(negedge clk_in);
            if (eng_start_out === 1'b1) begin
                if (exp_q.size() == 0) begin
                    chk("unexpected start", {eng_cmd_out, eng_addr_out}, 0);
                end else begin
                    chk("start", {eng_cmd_out, eng_addr_out},
                        exp_q.pop_front());
                end
                chk("count", 32'(eng_count_out), 32'h5);
                chk("data", eng_data_out[15:0], dw[2]);
                repeat (8) @(posedge clk_in);
                eng_done_in <= 1'b1;
                eng_viol_in <= viol_req;
                eng_result_in <= ~eng_data_out;
                @(posedge clk_in);
                eng_done_in <= 1'b0;
            end
        end
    end

    initial begin
        int   ph;
        int   t;
        logic v;
        rst_in = 1'b1;
        {avs_address_in, avs_read_in, avs_write_in} = '0;
        {avs_byteenable_in, avs_writedata_in} = '0;
        {special_mode_in, secure_state_in, resource_window_in} = '0;
        viol_req = 1'b0;
        n_fail = 0;
        n_tests = 0;
        ph = 0;
        t = 0;
        codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09,
                  8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12,
                  8'h13, 8'h05};
        void'($urandom(54));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rchk(8'h04, "status reset", 32'hb0, 32'h80);
        rchk(8'h00, "divider reset", 32'h80, 32'h0);
        rchk(8'h18, "unmapped", 32'hffffffff, 32'h0);
        launch(8'h06, 24'h001000, 1'b0, 1'b0);
        chk("unloaded program", rd & 32'hb0, 32'ha0);
        clr();
        // verify is neither program nor erase, so it runs unloaded
        launch(8'h01, 24'h0, 1'b0, 1'b1);
        chk("unloaded verify", rd & 32'hb0, 32'h80);
        bus(1'b1, 8'h00, 32'h3, 4'h1);
        rchk(8'h00, "divider", 32'hff, 32'h83);
        for (int k = 0; k < 12; k++) begin
            @(negedge clk_in);
            t += (flash_tick_out === 1'b1) ? 1 : 0;
        end
        chk("ticks", 32'(t), 32'h3);
        bus(1'b1, 8'h2c, 32'h1234, 4'h3);
        bus(1'b1, 8'h2c, 32'h00ff, 4'h2);
        rchk(8'h2c, "byte lane", 32'hffff, 32'h0034);
        bus(1'b1, 8'h0c, 32'hf, 4'h1);
        for (int m = 0; m < 4; m++) begin
            special_mode_in <= m[0];
            secure_state_in <= m[1];
            repeat (8) @(posedge clk_in);
            rchk(8'h10, "mode", 32'h3, 32'(m));
            for (int i = 0; i < 18; i++) begin
                v = valid_cmd(codes[i], m[0], m[1]);
                launch(codes[i], (codes[i] == 8'h07 || codes[i] == 8'h04) ?
                       24'(ph) : 24'($urandom), 1'b0,
                       v && codes[i] != 8'h04 && codes[i] != 8'h07);
                chk("cmd status",
                    rd & 32'hb0,
                    v ? 32'h80 : 32'ha0);
                if (v && codes[i] == 8'h07) begin
                    pdat = (ph == 0) ? dw[2] : pdat;
                    ph++;
                end
                clr();
            end
        end
        {special_mode_in, secure_state_in} <= 2'b00;
        repeat (8) @(posedge clk_in);
        rchk(8'h80, "info closed", 32'hffff, 32'h0);
        resource_window_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        rchk(8'h80, "info open", 32'hffff, {16'h0, pdat});
        launch(8'h07, 24'h0, 1'b0, 1'b0);
        chk("program once again", rd & 32'hb0, 32'ha0);
        clr();
        launch(8'h04, 24'h0, 1'b0, 1'b0);
        rchk(8'h28, "read once", 32'hffff, {16'h0, pdat});
        special_mode_in <= 1'b1;
        bus(1'b1, 8'h0c, 32'h7, 4'h1);
        launch(8'h08, 24'h0, 1'b0, 1'b0);
        chk("erase all guarded", rd & 32'hb0, 32'h90);
        bus(1'b1, 8'h04, 32'h80, 4'h1);
        rchk(8'h04, "launch with flag", 32'hb0, 32'h90);
        clr();
        bus(1'b1, 8'h0c, 32'h3, 4'h1);
        launch(8'h09, 24'h0, 1'b0, 1'b0);
        chk("erase block guarded", rd & 32'hb0, 32'h90);
        clr();
        bus(1'b1, 8'h0c, 32'hf, 4'h1);
        launch(8'h06, 24'h123456, 1'b1, 1'b1);
        chk("program done", rd & 32'hb0, 32'h80);
        rchk(8'h20, "locked word0", 32'hffff, 32'h0612);
        rchk(8'h28, "result word2", 32'hffff, {16'h0, ~dw[2]});
        viol_req = 1'b1;
        launch(8'h06, 24'h002000, 1'b0, 1'b1);
        chk("engine violation", rd & 32'hb0, 32'h90);
        chk("pending starts", 32'(exp_q.size()), 32'h0);
        complete_run();
    end
endmodule : testbench
